// ### common/recs_defs.svh
`ifndef RECS_DEFS_SVH
`define RECS_DEFS_SVH

// register offsets on the plain port
`define RECS_OFF_SEL0      4'h0
`define RECS_OFF_SEL1      4'h1
`define RECS_OFF_SEL2      4'h2
`define RECS_OFF_SEL3      4'h3
`define RECS_OFF_CFG0      4'h4
`define RECS_OFF_CFG1      4'h5
`define RECS_OFF_CFG2      4'h6
`define RECS_OFF_CFG3      4'h7
`define RECS_OFF_UOPSEL    4'h8
`define RECS_OFF_IRQ_STAT  4'h9
`define RECS_OFF_IRQ_MASK  4'hA
`define RECS_OFF_CNT0      4'hB
`define RECS_OFF_CNT1      4'hC
`define RECS_OFF_CNT2      4'hD
`define RECS_OFF_CNT3      4'hE

// event selector fields
`define RECS_EVSEL_HI      31
`define RECS_EVSEL_LO      25
`define RECS_EMASK_HI      24
`define RECS_EMASK_LO      9
// counter config fields
`define RECS_CSEL_HI       15
`define RECS_CSEL_LO       13
`define RECS_CFG_EN_BIT    12
`define RECS_CFG_EDGE_BIT  24

// event codes and config selects
`define RECS_EV_FP_ASSIST  7'h03
`define RECS_EV_FLUSH      7'h02
`define RECS_EV_COMPLETED  7'h07
`define RECS_CS_FP_ASSIST  3'h5
`define RECS_CS_FLUSH      3'h5
`define RECS_CS_COMPLETED  3'h4

// mask bit positions
`define RECS_M_STK_UNDER   0
`define RECS_M_STK_OVER    1
`define RECS_M_OUT_OVER    2
`define RECS_M_OUT_UNDER   3
`define RECS_M_IN_ASSIST   4
`define RECS_M_FLUSH_ANY   0
`define RECS_M_FLUSH_MEM   2
`define RECS_M_FLUSH_SMC   6
`define RECS_M_CORRECT     0
`define RECS_M_WRONG       1
`define RECS_M_LOAD_TAG    1
`define RECS_M_STORE_TAG   2

`define RECS_FLUSH_DUTY    2'h1
`define RECS_RST_32        32'h00000000

`endif

// ### common/recs_pkg.sv
package recs_pkg;

    // retirement-side event strobes from the core
    typedef struct packed {
        logic [4:0] fp_assist;   // under, over, out over, out under, input assist
        logic       flush_any;   // level while whole pipeline is flushed
        logic       flush_mem;   // one pulse per memory-order flush
        logic       flush_smc;   // one pulse per self-modifying-code flush
        logic [2:0] done_good;   // correct-path completions this cycle
        logic [2:0] done_bogus;  // wrong-path completions this cycle
    } recs_evt_t;

    // front-end tag outputs for load and store uops
    typedef struct packed {
        logic load_tag_bit;
        logic store_tag_bit;
    } recs_tag_t;

    typedef struct packed {
        logic [3:0]  wr;
        logic [3:0]  rd;
        logic [3:0]  addr;
        logic [31:0] data;
    } recs_bus_t;

endpackage : recs_pkg

// ### logic/recs_lane.sv
`timescale 1ns/1ps
`default_nettype none
`include "recs_defs.svh"

// one counter lane: decodes its selector and config, counts per cycle
module recs_lane
    import recs_pkg::*;
#(
    parameter logic [1:0] LANE = 2'h0
)
(
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic [31:0] event_selector_reg,
    input  wire logic [31:0] counter_config_reg,
    input  wire recs_evt_t   evt,
    input  wire logic        clr,
    output logic [31:0]      count,
    output logic             wrap
);

    typedef struct packed {
        logic [31:0] cnt;
        logic        prev;
        logic        duty;
        logic        wrap;
    } recs_lane_st_t;

    recs_lane_st_t st_r;
    recs_lane_st_t st_nxt;

    logic [6:0]  evsel;
    logic [15:0] emask;
    logic [2:0]  csel;
    logic        en;
    logic        edge_mode;
    logic [3:0]  inc;            // two 3-bit sums need four bits
    logic        cond;
    logic        any_flush_tick;

    assign evsel     = event_selector_reg[`RECS_EVSEL_HI:`RECS_EVSEL_LO];
    assign emask     = event_selector_reg[`RECS_EMASK_HI:`RECS_EMASK_LO];
    assign csel      = counter_config_reg[`RECS_CSEL_HI:`RECS_CSEL_LO];
    assign en        = counter_config_reg[`RECS_CFG_EN_BIT];
    assign edge_mode = counter_config_reg[`RECS_CFG_EDGE_BIT];

    // flush-any counts every other flush cycle; in edge mode the plain level
    // is used, else the duty toggle would give an edge every other flush cycle
    assign any_flush_tick = evt.flush_any && (edge_mode || !st_r.duty);

    // event decode; lanes 0/1 and 2/3 host different events
    always_comb
    begin
        inc = 4'h0;
        if (en && LANE[1] && evsel == `RECS_EV_FP_ASSIST && csel == `RECS_CS_FP_ASSIST)
        begin
            // any combination of assist causes
            inc = {3'h0, |(emask[4:0] & evt.fp_assist)};
        end
        else if (en && LANE[1] && evsel == `RECS_EV_FLUSH && csel == `RECS_CS_FLUSH)
        begin
            inc = {3'h0, (emask[`RECS_M_FLUSH_ANY] && any_flush_tick)
                       || (emask[`RECS_M_FLUSH_MEM] && evt.flush_mem)
                       || (emask[`RECS_M_FLUSH_SMC] && evt.flush_smc)};
        end
        else if (en && !LANE[1] && evsel == `RECS_EV_COMPLETED && csel == `RECS_CS_COMPLETED)
        begin
            // completions, not starts, feed these sums
            inc = (emask[`RECS_M_CORRECT] ? {1'b0, evt.done_good} : 4'h0)
                + (emask[`RECS_M_WRONG] ? {1'b0, evt.done_bogus} : 4'h0);
        end
    end

    assign cond = |inc;

    // state update; edge mode adds one on a rising condition only
    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.prev = cond;
        st_nxt.duty = evt.flush_any ? !st_r.duty : 1'b0;
        st_nxt.wrap = 1'b0;
        if (clr)
        begin
            st_nxt.cnt = `RECS_RST_32;
        end
        else if (edge_mode)
        begin
            if (cond && !st_r.prev)
            begin
                st_nxt.cnt  = st_r.cnt + 32'h00000001;
                st_nxt.wrap = &st_r.cnt;
            end
        end
        else
        begin
            st_nxt.cnt  = st_r.cnt + {28'h0, inc};
            st_nxt.wrap = ({1'b0, st_r.cnt} + {29'h0, inc}) > 33'h0FFFFFFFF;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign count = st_r.cnt;
    assign wrap  = st_r.wrap;

endmodule : recs_lane
`default_nettype wire

// ### logic/recs_top.sv
// What this block does
// - assist mask bit 0 counts stack underflow, bit 1 stack overflow.
// - assist mask bit 2 counts output overflow, bit 3 output underflow.
// - assist mask bit 4 counts input assist; any combination allowed.
// - flush event code 02H, config 05H, only on selectors 2 and 3.
// - flush-any bit counts part of flush cycles; use edge mode for occurrences.
// - flush mask bit 2 counts cycles with a memory-order flush; selected flush causes together add at most one per cycle.
// - flush mask bit 6 counts cycles with a self-modifying-code flush.
// - completed event code 07H, config 04H, only on selectors 0 and 1.
// - completed mask bit 0 counts correct path, bit 1 wrong path.
// - completed count reflects finished instructions, not started ones.
// - load and store tag bits only mark uops, never increment counters.
`timescale 1ns/1ps
`default_nettype none
`include "recs_defs.svh"

module recs_top
    import recs_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    input  wire recs_evt_t   core_evt,
    input  wire logic        uop_is_load,
    input  wire logic        uop_is_store,
    output recs_tag_t        uop_tag,
    output logic             irq
);

    // register state of the block, apart from the counts held in the lanes
    typedef struct packed {
        logic [3:0][31:0] sel;
        logic [3:0][31:0] cfg;
        logic [31:0]      uopsel;
        logic [3:0]       stat;
        logic [3:0]       mask;
        logic [31:0]      rdata;
        recs_tag_t        tag;
        logic             irq;
        recs_evt_t        evt;
    } recs_st_t;

    recs_st_t    st_r;
    recs_st_t    st_nxt;
    logic [3:0][31:0] cnt;
    logic [3:0]  wrap;
    logic [3:0]  clr;

    // four lanes; events are registered once since they come from core logic
    for (genvar g = 0; g < 4; g++)
    begin : g_lane
        recs_lane #(.LANE(2'(g))) u_lane
        (
            .sys_clk            (sys_clk),
            .arst_n             (arst_n),
            .event_selector_reg (st_r.sel[g]),
            .counter_config_reg (st_r.cfg[g]),
            .evt                (st_r.evt),
            .clr                (clr[g]),
            .count              (cnt[g]),
            .wrap               (wrap[g])
        );
    end

    // counter clear on a write to its count offset
    function automatic logic hits(input logic [3:0] a, input logic [3:0] off);
        hits = (a == off);
    endfunction : hits

    always_comb
    begin
        for (int i = 0; i < 4; i++)
            clr[i] = reg_wr && hits(reg_addr, 4'(`RECS_OFF_CNT0 + i));
    end

    always_comb
    begin
        st_nxt     = st_r;
        st_nxt.evt = core_evt;
        // tags only mark uops; no counter ever sees them
        st_nxt.tag.load_tag_bit  = uop_is_load  && st_r.uopsel[`RECS_EMASK_LO + `RECS_M_LOAD_TAG];
        st_nxt.tag.store_tag_bit = uop_is_store && st_r.uopsel[`RECS_EMASK_LO + `RECS_M_STORE_TAG];
        // register writes
        if (reg_wr)
        begin
            case (reg_addr)
                `RECS_OFF_SEL0:     st_nxt.sel[0] = reg_wdata;
                `RECS_OFF_SEL1:     st_nxt.sel[1] = reg_wdata;
                `RECS_OFF_SEL2:     st_nxt.sel[2] = reg_wdata;
                `RECS_OFF_SEL3:     st_nxt.sel[3] = reg_wdata;
                `RECS_OFF_CFG0:     st_nxt.cfg[0] = reg_wdata;
                `RECS_OFF_CFG1:     st_nxt.cfg[1] = reg_wdata;
                `RECS_OFF_CFG2:     st_nxt.cfg[2] = reg_wdata;
                `RECS_OFF_CFG3:     st_nxt.cfg[3] = reg_wdata;
                `RECS_OFF_UOPSEL:   st_nxt.uopsel = reg_wdata;
                `RECS_OFF_IRQ_MASK: st_nxt.mask = reg_wdata[3:0];
                default:            st_nxt.uopsel = st_r.uopsel;
            endcase
        end
        // status read clears; a wrap in the same cycle still wins
        st_nxt.rdata = `RECS_RST_32;
        if (reg_rd)
        begin
            case (reg_addr)
                `RECS_OFF_SEL0:     st_nxt.rdata = st_r.sel[0];
                `RECS_OFF_SEL1:     st_nxt.rdata = st_r.sel[1];
                `RECS_OFF_SEL2:     st_nxt.rdata = st_r.sel[2];
                `RECS_OFF_SEL3:     st_nxt.rdata = st_r.sel[3];
                `RECS_OFF_CFG0:     st_nxt.rdata = st_r.cfg[0];
                `RECS_OFF_CFG1:     st_nxt.rdata = st_r.cfg[1];
                `RECS_OFF_CFG2:     st_nxt.rdata = st_r.cfg[2];
                `RECS_OFF_CFG3:     st_nxt.rdata = st_r.cfg[3];
                `RECS_OFF_UOPSEL:   st_nxt.rdata = st_r.uopsel;
                `RECS_OFF_IRQ_STAT:
                begin
                    st_nxt.rdata = {28'h0, st_r.stat};
                    st_nxt.stat  = 4'h0;
                end
                `RECS_OFF_IRQ_MASK: st_nxt.rdata = {28'h0, st_r.mask};
                `RECS_OFF_CNT0:     st_nxt.rdata = cnt[0];
                `RECS_OFF_CNT1:     st_nxt.rdata = cnt[1];
                `RECS_OFF_CNT2:     st_nxt.rdata = cnt[2];
                `RECS_OFF_CNT3:     st_nxt.rdata = cnt[3];
                default:            st_nxt.rdata = `RECS_RST_32;
            endcase
        end
        st_nxt.stat = st_nxt.stat | wrap;
        st_nxt.irq  = |(st_nxt.stat & st_nxt.mask);
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign reg_rdata = st_r.rdata;
    assign uop_tag   = st_r.tag;
    assign irq       = st_r.irq;

endmodule : recs_top
`default_nettype wire

// ### verif/recs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module recs_chk
    import recs_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [31:0] reg_rdata,
    input  wire recs_evt_t   core_evt,
    input  wire logic        uop_is_load,
    input  wire logic        uop_is_store,
    input  wire recs_tag_t   uop_tag,
    input  wire logic        irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    logic [31:0] mask_r;
    logic [31:0] uop_r;

    // shadows of mask and uop selector, so gating can be judged from ports
    always_ff @(posedge sys_clk or negedge arst_n)
        if (!arst_n)
            {mask_r, uop_r} <= '0;
        else if (reg_wr && reg_addr == 4'hA)
            mask_r <= reg_wdata;
        else if (reg_wr && reg_addr == 4'h8)
            uop_r <= reg_wdata;

    // read port and interrupt
    AST_RDATA_SLOT: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its slot");
    AST_UNMAPPED: assert property (reg_rd && reg_addr == 4'hF |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    AST_IRQ_MASKED: assert property (mask_r == 32'h0 && $past(mask_r) == 32'h0 |-> !irq)
        else $error("irq with every source masked");
    // tags follow the uop one cycle later, gated by the selector bits
    AST_TAG_LOAD: assert property ($past(arst_n) |-> uop_tag.load_tag_bit == $past(uop_is_load && uop_r[10]))
        else $error("load tag wrong");
    AST_TAG_STORE: assert property ($past(arst_n) |-> uop_tag.store_tag_bit == $past(uop_is_store && uop_r[11]))
        else $error("store tag wrong");
    AST_TAG_IDLE: assert property (!(uop_is_load || uop_is_store) |=> uop_tag == '0)
        else $error("tag without a uop");
    // three idle cycles drain the event pipe, so a counter must hold still
    AST_CNT_STABLE: assert property (
        (!reg_wr && core_evt == '0)[*3] ##0 (reg_rd && reg_addr == 4'hB) ##1 (reg_rd && reg_addr == 4'hB)
        |=> reg_rdata == $past(reg_rdata))
        else $error("quiet counter moved");
    AST_CNT_CLEAR: assert property ((reg_wr && reg_addr >= 4'hB && reg_addr != 4'hF && core_evt == '0
        && $past(core_evt) == '0) ##2 (reg_rd && reg_addr == $past(reg_addr, 2)) |=> reg_rdata == 32'h0)
        else $error("counter not cleared");

    cover property (reg_rd && reg_addr == 4'hB ##1 reg_rdata != 32'h0);
    cover property (uop_tag.load_tag_bit);
    cover property (uop_tag.store_tag_bit);
endmodule : recs_chk

bind recs_top recs_chk u_chk (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_evt(core_evt), .uop_is_load(uop_is_load),
    .uop_is_store(uop_is_store), .uop_tag(uop_tag), .irq(irq));
`default_nettype wire

// ### verif/retire_event_counter_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
module retire_event_counter_select_tb;
    import recs_pkg::*;
    logic        sys_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        uop_is_load = 1'b0;
    logic        uop_is_store = 1'b0;
    recs_evt_t   core_evt = '0;
    logic [31:0] reg_rdata;
    recs_tag_t   uop_tag;
    logic        irq;
    int          num_errors = 0;
    int          compares = 0;
    int          cycles = 0;

    always #25 sys_clk = ~sys_clk;

    recs_top DUT (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_evt(core_evt),
        .uop_is_load(uop_is_load), .uop_is_store(uop_is_store), .uop_tag(uop_tag), .irq(irq));

    task complete_run;
        if (num_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    // idle cycle after each strobe keeps one assignment per time step
    task wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr

    task rd(input logic [3:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
        @(posedge sys_clk);
    endtask : rd

    // program a lane, clear it, hold an event n cycles, read the count
    task run(input logic [1:0] l, input logic [31:0] sel, input logic [31:0] cfg, input recs_evt_t e,
        input int n, input logic [31:0] exp);
        logic [31:0] v;
        wr({2'h0, l}, sel);
        wr({2'h1, l}, cfg);
        wr(4'hB + {2'h0, l}, 32'h0);
        rd(4'hB + {2'h0, l}, v);
        chk("cleared count", v, 32'h0);
        core_evt <= e;
        repeat (n) @(posedge sys_clk);
        core_evt <= '0;
        @(posedge sys_clk);
        rd(4'hB + {2'h0, l}, v);
        chk("count", v, exp);
    endtask : run

    task test_assist;
        recs_evt_t e;
        e = '0;
        for (int i = 0; i < 5; i++)
        begin
            e.fp_assist = 5'h1F;
            run(2'h2, {7'h03, 16'h0001 << i, 9'h0}, 32'h0000B000, e, 1, 32'h1);
            e.fp_assist = ~(5'h01 << i);
            run(2'h3, {7'h03, 16'h0001 << i, 9'h0}, 32'h0000B000, e, 1, 32'h0);
            e.fp_assist = 5'h01 << i;
            run(2'h2, {7'h03, 16'h001F, 9'h0}, 32'h0000B000, e, 1, 32'h1);
        end
    endtask : test_assist

    task test_flush;
        recs_evt_t e;
        e = '0;
        e.flush_any = 1'b1;
        run(2'h3, {7'h02, 16'h0001, 9'h0}, 32'h0000B000, e, 4, 32'h2);
        run(2'h2, {7'h02, 16'h0001, 9'h0}, 32'h0100B000, e, 4, 32'h1);
        run(2'h0, {7'h02, 16'h0001, 9'h0}, 32'h0000B000, e, 4, 32'h0);
        e = '0;
        e.flush_mem = 1'b1;
        run(2'h3, {7'h02, 16'h0004, 9'h0}, 32'h0000B000, e, 1, 32'h1);
        run(2'h2, {7'h02, 16'h0040, 9'h0}, 32'h0000B000, e, 1, 32'h0);
        e = '0;
        e.flush_smc = 1'b1;
        run(2'h2, {7'h02, 16'h0040, 9'h0}, 32'h0000B000, e, 1, 32'h1);
    endtask : test_flush

    task test_completed;
        recs_evt_t e;
        e = '0;
        e.done_good = 3'h3;
        e.done_bogus = 3'h5;
        run(2'h0, {7'h07, 16'h0001, 9'h0}, 32'h00009000, e, 2, 32'h6);
        run(2'h1, {7'h07, 16'h0002, 9'h0}, 32'h00009000, e, 2, 32'hA);
        run(2'h0, {7'h07, 16'h0003, 9'h0}, 32'h00009000, e, 1, 32'h8);
        run(2'h2, {7'h07, 16'h0001, 9'h0}, 32'h00009000, e, 2, 32'h0);
        run(2'h1, {7'h07, 16'h0001, 9'h0}, 32'h01009000, e, 3, 32'h1);
    endtask : test_completed

    // tagging, unmapped read, status, back-to-back counter reads
    task test_misc;
        logic [31:0] v;
        for (int k = 0; k < 2; k++)
        begin
            wr(4'h8, 32'h00000400 << k);
            uop_is_load <= 1'b1;
            uop_is_store <= 1'b1;
            @(posedge sys_clk);
            uop_is_load <= 1'b0;
            uop_is_store <= 1'b0;
            @(negedge sys_clk);
            chk("uop tag", {30'h0, uop_tag}, 32'h2 >> k);
            @(posedge sys_clk);
        end
        rd(4'hC, v);
        chk("count after tagging", v, 32'h1);
        wr(4'hA, 32'h0000000F);
        rd(4'hF, v);
        chk("unmapped read", v, 32'h0);
        rd(4'h9, v);
        chk("status", v, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        reg_addr <= 4'hB;
        reg_rd <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
    endtask : test_misc

    initial
    begin
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        test_assist();
        test_flush();
        test_completed();
        test_misc();
        complete_run();
    end

    // a hang counts as a mismatch
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            complete_run();
        end
    end
endmodule : retire_event_counter_select_tb
`default_nettype wire
